// ==== core/dsc_pkg.sv ====
// Constants, reset values and carrier types of the converter register bank
// Assumes a single 20 MHz clock and an I2C-compatible host on the pins
package dsc_pkg;

  // ----------------------------------------
  // Register offsets and lock window
  // ----------------------------------------
  localparam logic [7:0] OFS_LOCK = 8'h0d;
  localparam logic [7:0] OFS_ILIM = 8'h0f;
  localparam logic [7:0] OFS_PGS  = 8'h10;
  localparam logic [7:0] OFS_UV   = 8'h11;
  localparam logic [7:0] OFS_PAD  = 8'h13;
  localparam logic [7:0] OFS_ADR  = 8'h14;
  localparam logic [7:0] OFS_VAR  = 8'h30;
  localparam logic [7:0] OFS_PID  = 8'h31;
  localparam logic [7:0] OFS_CUS  = 8'h32;
  localparam logic [7:0] OFS_REV  = 8'h33;
  localparam logic [7:0] LOCK_LO  = 8'h0e;
  localparam logic [7:0] LOCK_HI  = 8'h2f;
  localparam logic [7:0] LOCK_KEY = 8'h4a;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ILIM = 8'h1c;
  localparam logic [7:0] RST_PGS  = 8'h17;
  localparam logic [7:0] RST_UV   = 8'h60;
  localparam logic [7:0] RST_PAD  = 8'hd9;
  localparam logic [7:0] RST_ADR  = 8'hcd;
  localparam logic [7:0] RST_ID   = 8'h00;

  // ----------------------------------------
  // Field decoding and timing
  // ----------------------------------------
  localparam logic [4:0]  PG_SAT_CODE  = 5'h19;
  localparam logic [13:0] ILIM_BASE_MA = 14'h12c0;
  localparam logic [9:0]  ILIM_STEP_MA = 10'h1c2;
  localparam int          CLK_NS       = 50;
  localparam int          MS_NS        = 1000000;
  localparam int          MS_CYCLES    = MS_NS / CLK_NS;
  localparam logic [8:0]  PAUSE_MS_1   = 9'h00a;
  localparam logic [8:0]  PAUSE_MS_2   = 9'h064;
  localparam logic [8:0]  PAUSE_MS_3   = 9'h1f4;

  typedef struct packed {
    logic [3:0] peak_current_limit_code;
    logic       power_good_comparator_off;
    logic [4:0] power_good_threshold;
    logic [1:0] startup_current_limit;
    logic [2:0] input_undervoltage_hysteresis;
    logic [4:0] input_undervoltage_critical_level;
    logic       pad_supply_regulator_on;
    logic [1:0] power_cycle_pause_select;
    logic [1:0] pad_supply_voltage_select;
    logic [2:0] input_undervoltage_warning_level;
    logic [3:0] target_address_upper_nibble;
  } dsc_cfg_t;

  typedef struct packed {
    logic [13:0] peak_limit_ma;
    logic [4:0]  power_good_threshold_eff;
  } dsc_level_t;

endpackage

// ==== core/dsc_i2c_target.sv ====
// I2C-compatible target: address match, register pointer, reads and writes
// Assumes scl and sda_in synchronous to clock and much slower than it
`timescale 1ns/100ps
module dsc_i2c_target (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic [3:0] addr_nibble,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe,
  output logic [7:0]      reg_addr,
  output logic            wr_stb,
  output logic [7:0]      wr_data
);
  import dsc_pkg::*;

  typedef enum logic [3:0] {
    IDLE, ADDR, AACK, PTR, PACK, WDATA, WACK, RDATA, RACK
  } dsc_i2c_st_t;

  dsc_i2c_st_t st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  sh, next_sh, next_reg_addr, next_wr_data;
  logic        rw, next_rw, next_sda_oe, next_wr_stb;
  logic        scl_q, sda_q;
  logic        rise, fall, start, stop;

  assign rise  = scl & ~scl_q;
  assign fall  = ~scl & scl_q;
  assign start = scl & scl_q & sda_q & ~sda_in;
  assign stop  = scl & scl_q & ~sda_q & sda_in;

  // ----------------------------------------
  // Bus framing
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_cnt      = cnt;
    next_sh       = sh;
    next_rw       = rw;
    next_sda_oe   = sda_oe;
    next_reg_addr = reg_addr;
    next_wr_data  = wr_data;
    next_wr_stb   = 1'b0;
    if (start) begin
      next_st     = ADDR;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop) begin
      next_st     = IDLE;
      next_sda_oe = 1'b0;
    end else if (rise) begin
      if (st == ADDR || st == PTR || st == WDATA) begin
        next_sh  = {sh[6:0], sda_in};
        next_cnt = cnt + 4'h1;
      end else if (st == RDATA) begin
        next_cnt = cnt + 4'h1;
      end else if (st == RACK && sda_in) begin
        next_st = IDLE;
      end
    end else if (fall) begin
      unique case (st)
        IDLE: ;
        ADDR: if (cnt == 4'h8) begin
          next_cnt = 4'h0;
          if (sh[7:1] == {addr_nibble, 3'h0}) begin
            next_rw     = sh[0];
            next_sda_oe = 1'b1;
            next_st     = AACK;
          end else begin
            next_st = IDLE;
          end
        end
        AACK: if (rw) begin
          next_sh     = rd_data;
          next_sda_oe = ~rd_data[7];
          next_st     = RDATA;
        end else begin
          next_sda_oe = 1'b0;
          next_st     = PTR;
        end
        PTR: if (cnt == 4'h8) begin
          next_reg_addr = sh;
          next_cnt      = 4'h0;
          next_sda_oe   = 1'b1;
          next_st       = PACK;
        end
        PACK: begin
          next_sda_oe = 1'b0;
          next_st     = WDATA;
        end
        WDATA: if (cnt == 4'h8) begin
          next_wr_stb  = 1'b1;
          next_wr_data = sh;
          next_cnt     = 4'h0;
          next_sda_oe  = 1'b1;
          next_st      = WACK;
        end
        WACK: begin
          next_sda_oe   = 1'b0;
          next_reg_addr = reg_addr + 8'h01;
          next_st       = WDATA;
        end
        RDATA: if (cnt == 4'h8) begin
          next_sda_oe   = 1'b0;
          next_reg_addr = reg_addr + 8'h01;
          next_st       = RACK;
        end else begin
          next_sh     = {sh[6:0], 1'b0};
          next_sda_oe = ~sh[6];
        end
        RACK: begin
          next_sh     = rd_data;
          next_sda_oe = ~rd_data[7];
          next_cnt    = 4'h0;
          next_st     = RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st       <= IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      reg_addr <= 8'h00;
      wr_stb   <= 1'b0;
      wr_data  <= 8'h00;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      st       <= next_st;
      cnt      <= next_cnt;
      sh       <= next_sh;
      rw       <= next_rw;
      sda_oe   <= next_sda_oe;
      reg_addr <= next_reg_addr;
      wr_stb   <= next_wr_stb;
      wr_data  <= next_wr_data;
      scl_q    <= scl;
      sda_q    <= sda_in;
    end
  end

endmodule

// ==== core/dsc_config_bank.sv ====
// Configuration and identification register bank of the divider converter
// Assumes an I2C-compatible host on scl and sda; sda is open drain outside
//
// What this block does
// - Peak limit code, 450 mA steps, reset 0xC
// - Bit 7 set turns power-good comparator off
// - Power-good threshold saturates above code 25
// - Start-up current two-bit code, reset 11
// - Undervoltage hysteresis three-bit code, reset 011
// - Critical undervoltage five-bit code, reset zero
// - Pad regulator enable bit, reset one
// - Power cycle waits selected pause before reboot
// - Pad supply voltage two-bit select, reset 11
// - Undervoltage warning three-bit code, reset 001
// - Target address upper nibble, reset 1101
// - Variant register: revision and package nibbles
// - Customer platform tag, reset zero
// - Settings revision, zero means unconfigured
// - Key unlocks 0x0E..0x2F writes, else locked
`timescale 1ns/100ps
module dsc_config_bank #(
  parameter int         CYCLES_PER_MS = dsc_pkg::MS_CYCLES,
  parameter logic [7:0] PART_ID       = 8'h5a  // Arbitrary identification value
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         scl,
  input  wire logic         sda_in,
  input  wire logic         power_cycle,
  output logic              sda_out,
  output logic              sda_oe,
  output dsc_pkg::dsc_cfg_t   cfg,
  output dsc_pkg::dsc_level_t level,
  output logic              reboot_hold,
  output logic              reboot_go
);
  import dsc_pkg::*;

  localparam int CW = $clog2(CYCLES_PER_MS + 1);

  logic [7:0] r_ilim, r_pgs, r_uv, r_pad, r_adr, r_var, r_cus, r_rev;
  logic [7:0] next_ilim, next_pgs, next_uv, next_pad, next_adr;
  logic [7:0] next_var, next_cus, next_rev;
  logic       unlocked, next_unlocked;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic       wr_stb, may_write, in_window;

  // ----------------------------------------
  // Serial target
  // ----------------------------------------
  dsc_i2c_target u_i2c (
    .clock       (clock),
    .nrst        (nrst),
    .scl         (scl),
    .sda_in      (sda_in),
    .addr_nibble (r_adr[3:0]),
    .rd_data     (rd_data),
    .sda_oe      (sda_oe),
    .reg_addr    (reg_addr),
    .wr_stb      (wr_stb),
    .wr_data     (wr_data)
  );

  assign sda_out = 1'b0;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign in_window = (reg_addr >= LOCK_LO) && (reg_addr <= LOCK_HI);
  assign may_write = wr_stb && (!in_window || unlocked);

  always_comb begin
    next_unlocked = unlocked;
    next_ilim     = r_ilim;
    next_pgs      = r_pgs;
    next_uv       = r_uv;
    next_pad      = r_pad;
    next_adr      = r_adr;
    next_var      = r_var;
    next_cus      = r_cus;
    next_rev      = r_rev;
    if (may_write) begin
      unique case (reg_addr)
        OFS_LOCK: next_unlocked = (wr_data == LOCK_KEY);
        OFS_ILIM: next_ilim = wr_data;
        OFS_PGS:  next_pgs  = wr_data;
        OFS_UV:   next_uv   = wr_data;
        OFS_PAD:  next_pad  = wr_data;
        OFS_ADR:  next_adr  = wr_data;
        OFS_VAR:  next_var  = wr_data;
        OFS_CUS:  next_cus  = wr_data;
        OFS_REV:  next_rev  = wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unlocked <= 1'b0;
      r_ilim   <= RST_ILIM;
      r_pgs    <= RST_PGS;
      r_uv     <= RST_UV;
      r_pad    <= RST_PAD;
      r_adr    <= RST_ADR;
      r_var    <= RST_ID;
      r_cus    <= RST_ID;
      r_rev    <= RST_ID;
    end else begin
      unlocked <= next_unlocked;
      r_ilim   <= next_ilim;
      r_pgs    <= next_pgs;
      r_uv     <= next_uv;
      r_pad    <= next_pad;
      r_adr    <= next_adr;
      r_var    <= next_var;
      r_cus    <= next_cus;
      r_rev    <= next_rev;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    unique case (reg_addr)
      OFS_LOCK: rd_data = unlocked ? LOCK_KEY : 8'h00;
      OFS_ILIM: rd_data = r_ilim;
      OFS_PGS:  rd_data = r_pgs;
      OFS_UV:   rd_data = r_uv;
      OFS_PAD:  rd_data = r_pad;
      OFS_ADR:  rd_data = r_adr;
      OFS_VAR:  rd_data = r_var;
      OFS_PID:  rd_data = PART_ID;
      OFS_CUS:  rd_data = r_cus;
      OFS_REV:  rd_data = r_rev;
      default:  rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  // Configuration fields, comparator off bit among them
  assign cfg = '{
    peak_current_limit_code:           r_ilim[3:0],
    power_good_comparator_off:         r_pgs[7],
    power_good_threshold:              r_pgs[6:2],
    startup_current_limit:             r_pgs[1:0],
    input_undervoltage_hysteresis:     r_uv[7:5],
    input_undervoltage_critical_level: r_uv[4:0],
    pad_supply_regulator_on:           r_pad[7],
    power_cycle_pause_select:          r_pad[6:5],
    pad_supply_voltage_select:         r_pad[4:3],
    input_undervoltage_warning_level:  r_pad[2:0],
    target_address_upper_nibble:       r_adr[3:0]
  };

  dsc_level_t next_level;

  always_comb begin
    next_level.peak_limit_ma = ILIM_BASE_MA + 14'(ILIM_STEP_MA) * 14'(r_ilim[3:0]);
    next_level.power_good_threshold_eff =
      (r_pgs[6:2] > PG_SAT_CODE) ? PG_SAT_CODE : r_pgs[6:2];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  // ----------------------------------------
  // Power cycle pause
  // ----------------------------------------
  logic [CW-1:0] cyc, next_cyc;
  logic [8:0]    ms_left, next_ms_left, pause_ms;
  logic          next_hold, next_go, ms_tick;

  always_comb begin
    unique case (r_pad[6:5])
      2'h0: pause_ms = 9'h000;
      2'h1: pause_ms = PAUSE_MS_1;
      2'h2: pause_ms = PAUSE_MS_2;
      2'h3: pause_ms = PAUSE_MS_3;
    endcase
  end

  assign ms_tick = (cyc == CW'(CYCLES_PER_MS - 1));

  always_comb begin
    next_cyc     = cyc;
    next_ms_left = ms_left;
    next_hold    = reboot_hold;
    next_go      = 1'b0;
    if (power_cycle) begin
      next_cyc     = '0;
      next_ms_left = pause_ms;
      next_hold    = (pause_ms != 9'h000);
      next_go      = (pause_ms == 9'h000);
    end else if (reboot_hold) begin
      next_cyc = ms_tick ? '0 : cyc + CW'(1);
      if (ms_tick) begin
        next_ms_left = ms_left - 9'h001;
        if (ms_left == 9'h001) begin
          next_hold = 1'b0;
          next_go   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cyc         <= '0;
      ms_left     <= 9'h000;
      reboot_hold <= 1'b0;
      reboot_go   <= 1'b0;
    end else begin
      cyc         <= next_cyc;
      ms_left     <= next_ms_left;
      reboot_hold <= next_hold;
      reboot_go   <= next_go;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_key_write;
    wr_stb && reg_addr == OFS_LOCK && wr_data == LOCK_KEY;
  endsequence

  sequence s_locked_write;
    wr_stb && !unlocked && in_window;
  endsequence

  property p_lock_key;
    s_key_write |=> unlocked ##1 (rd_data == LOCK_KEY || reg_addr != OFS_LOCK);
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("key did not unlock");

  property p_lock_block;
    s_locked_write |=> $stable(r_ilim) && $stable(r_pgs) && $stable(r_uv) &&
                       $stable(r_pad) && $stable(r_adr);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("locked write landed");

  property p_relock;
    wr_stb && reg_addr == OFS_LOCK && wr_data != LOCK_KEY |=> !unlocked;
  endproperty
  a_relock: assert property (p_relock) else $error("bad key left unlocked");

  property p_pg_sat;
    r_pgs[6:2] > PG_SAT_CODE |=> level.power_good_threshold_eff == 5'h19;
  endproperty
  a_pg_sat: assert property (p_pg_sat) else $error("threshold not saturated");

  property p_ilim_ma;
    1'b1 |=> level.peak_limit_ma == 14'(4800 + 450 * $past(r_ilim[3:0]));
  endproperty
  a_ilim_ma: assert property (p_ilim_ma) else $error("peak limit wrong");

  property p_pause_zero;
    power_cycle && r_pad[6:5] == 2'h0 |=> reboot_go && !reboot_hold;
  endproperty
  a_pause_zero: assert property (p_pause_zero) else $error("no-wait pause held");

  sequence s_pause_armed;
    power_cycle && r_pad[6:5] != 2'h0 ##1 (!power_cycle) [*7];
  endsequence

  property p_pause_hold;
    s_pause_armed |-> reboot_hold && !reboot_go;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause ended early");

  property p_pad_write;
    wr_stb && reg_addr == OFS_PAD && unlocked |=> r_pad == $past(wr_data);
  endproperty
  a_pad_write: assert property (p_pad_write) else $error("pad write lost");

  property p_rev_write;
    wr_stb && reg_addr == OFS_REV ##1 reg_addr == OFS_REV |-> rd_data == $past(wr_data);
  endproperty
  a_rev_write: assert property (p_rev_write) else $error("revision write lost");

endmodule

// ==== sim/dsc_host_model.sv ====
// I2C host model that sets up the converter register bank
// Assumes sda is open drain with a pull-up and the bank clock runs freely
`timescale 1ns/100ps
module dsc_host_model (
  input  wire logic clock,
  input  wire logic dev_sda_oe,
  output logic      scl,
  output logic      sda_in
);
  logic pull_low;

  // Wired-and of both drivers with a pull-up
  assign sda_in = !(pull_low || dev_sda_oe);

  initial begin
    scl      = 1'b1;
    pull_low = 1'b0;
  end

  // ----------------------------------------
  // Bus phases, four clock cycles each
  // ----------------------------------------
  task automatic gap();
    repeat (4) @(negedge clock);
  endtask

  task automatic start();
    pull_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    pull_low = 1'b1;
    gap();
    scl = 1'b0;
    gap();
  endtask

  task automatic stop();
    pull_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    pull_low = 1'b0;
    gap();
  endtask

  task automatic bit_io(input logic b, output logic s);
    pull_low = !b;
    gap();
    scl = 1'b1;
    gap();
    s   = sda_in;
    scl = 1'b0;
    gap();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule

// ==== sim/test_dsc_config_bank.sv ====
// Self-checking bench of the converter register bank
// Assumes the host model drives scl and the wired sda level
`timescale 1ns/100ps
module test_dsc_config_bank;
  import dsc_pkg::*;
  localparam int         CPM = 4;
  localparam logic [7:0] PID = 8'h3c;  // Arbitrary identification value
  localparam logic [7:0] RA[10] = '{8'h0f, 8'h10, 8'h11, 8'h13, 8'h14,
                                    8'h30, 8'h31, 8'h32, 8'h33, 8'h0d};
  localparam logic [7:0] RV[10] = '{8'h1c, 8'h17, 8'h60, 8'hd9, 8'hcd,
                                    8'h00, PID, 8'h00, 8'h00, 8'h00};
  localparam int         PMS[4] = '{0, 10, 100, 500};
  localparam logic [4:0] PG[5]  = '{5'h00, 5'h18, 5'h19, 5'h1a, 5'h1f};

  logic       clock, nrst, power_cycle, scl, sda_in, sda_oe;
  logic       reboot_hold, reboot_go, k;
  logic [6:0] dev_adr;
  dsc_cfg_t   cfg;
  dsc_level_t level;
  int         err_total, n_compared, n;

  always #25 clock = ~clock;

  dsc_host_model host (
    .clock      (clock),
    .dev_sda_oe (sda_oe),
    .scl        (scl),
    .sda_in     (sda_in)
  );

  dsc_config_bank #(.CYCLES_PER_MS(CPM), .PART_ID(PID)) dut (
    .clock       (clock),
    .nrst        (nrst),
    .scl         (scl),
    .sda_in      (sda_in),
    .power_cycle (power_cycle),
    .sda_out     (),
    .sda_oe      (sda_oe),
    .cfg         (cfg),
    .level       (level),
    .reboot_hold (reboot_hold),
    .reboot_go   (reboot_go)
  );

  // ----------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    host.start();
    host.send_byte({dev_adr, 1'b0}, k1);
    host.send_byte(a, k2);
    host.send_byte(d, k3);
    host.stop();
    chk("write acks", {k1, k2, k3}, 3'b111);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic       k1, k2, k3;
    logic [7:0] d;
    host.start();
    host.send_byte({dev_adr, 1'b0}, k1);
    host.send_byte(a, k2);
    host.start();
    host.send_byte({dev_adr, 1'b1}, k3);
    host.recv_byte(1'b1, d);
    host.stop();
    chk("read acks", {k1, k2, k3}, 3'b111);
    chk($sformatf("register %h", a), d, exp);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clock       = 1'b0;
    nrst        = 1'b0;
    power_cycle = 1'b0;
    dev_adr     = 7'h68;
    err_total   = 0;
    n_compared  = 0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    foreach (RA[i]) rchk(RA[i], RV[i]);
    chk("peak limit", level.peak_limit_ma, 16'd10200);
    chk("pg level", level.power_good_threshold_eff, 16'h5);
    chk("pause select", cfg.power_cycle_pause_select, 16'h2);
    chk("address nibble", cfg.target_address_upper_nibble, 16'hd);
    $display("test reset values done");

    wr(OFS_PGS, 8'h00);
    rchk(OFS_PGS, RST_PGS);
    wr(OFS_LOCK, LOCK_KEY);
    rchk(OFS_LOCK, LOCK_KEY);
    $display("test lock done");

    for (int c = 0; c < 16; c++) begin
      wr(OFS_ILIM, {4'h1, c[3:0]});
      chk("peak code", cfg.peak_current_limit_code, 16'(c));
      chk("peak limit", level.peak_limit_ma, 16'(4800 + 450 * c));
    end
    // Host leaves limit below ten amperes
    wr(OFS_ILIM, 8'h1b);
    $display("test peak limit done");

    foreach (PG[i]) begin
      wr(OFS_PGS, {1'b1, PG[i], 2'b01});
      chk("comparator off", cfg.power_good_comparator_off, 16'h1);
      chk("pg code", cfg.power_good_threshold, 16'(PG[i]));
      chk("pg level", level.power_good_threshold_eff, 16'(PG[i] > 25 ? 25 : PG[i]));
      chk("startup", cfg.startup_current_limit, 16'h1);
    end
    $display("test power good done");

    wr(OFS_UV, 8'hbf);
    chk("uv hysteresis", cfg.input_undervoltage_hysteresis, 16'h5);
    chk("uv critical", cfg.input_undervoltage_critical_level, 16'h1f);
    // Host keeps critical level at 5.0 V or more
    wr(OFS_UV, 8'h68);
    wr(OFS_PAD, 8'h12);
    chk("pad regulator", cfg.pad_supply_regulator_on, 16'h0);
    chk("pad voltage", cfg.pad_supply_voltage_select, 16'h2);
    chk("uv warning", cfg.input_undervoltage_warning_level, 16'h2);
    $display("test thresholds done");

    for (int c = 0; c < 4; c++) begin
      wr(OFS_PAD, {1'b1, c[1:0], 5'h19});
      power_cycle = 1'b1;
      @(negedge clock);
      power_cycle = 1'b0;
      n = 1;
      chk("pause hold", reboot_hold, 16'(c != 0));
      while (reboot_go !== 1'b1 && n < 3000) begin
        @(negedge clock);
        n++;
      end
      chk("pause length", 16'(n), 16'(c == 0 ? 1 : 1 + PMS[c] * CPM));
      chk("hold after pause", reboot_hold, 16'h0);
      if (n >= 3000) wrap_up();
    end
    $display("test power cycle pause done");

    wr(OFS_ADR, 8'hc3);
    dev_adr = 7'h18;
    rchk(OFS_ADR, 8'hc3);
    chk("address nibble", cfg.target_address_upper_nibble, 16'h3);
    host.start();
    host.send_byte(8'hd0, k);
    host.stop();
    chk("old address ack", k, 16'h0);
    $display("test bus address done");

    wr(OFS_VAR, 8'ha3);
    rchk(OFS_VAR, 8'ha3);
    wr(OFS_CUS, 8'h5e);
    rchk(OFS_CUS, 8'h5e);
    wr(OFS_REV, 8'h07);
    rchk(OFS_REV, 8'h07);
    wr(OFS_PID, 8'hff);
    rchk(OFS_PID, PID);
    rchk(8'h40, 8'h00);
    $display("test identification done");

    wr(OFS_LOCK, 8'h00);
    rchk(OFS_LOCK, 8'h00);
    wr(OFS_UV, 8'h00);
    rchk(OFS_UV, 8'h68);
    $display("test relock done");
    wrap_up();
  end
endmodule
